//--- hw/spi_chain_defines.svh
`ifndef SPI_CHAIN_DEFINES_SVH
`define SPI_CHAIN_DEFINES_SVH

// Clock period of ref_clk in ns
`define CLK_PERIOD_NS 20
// Sleep pin deglitch time and fault-clear pulse limit, ns
`define T_DEGLITCH_NS 5000
`define T_CLEAR_MAX_NS 20000
// Least time rounds up, longest time rounds down
`define DEGLITCH_CYC ((`T_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_MAX_CYC (`T_CLEAR_MAX_NS / `CLK_PERIOD_NS)
// Default wake delay in cycles
`define WAKE_CYC_DEF 50
// Low-pulse counter saturation
`define LOW_CNT_MAX 11'h7FF
// Frame layout
`define WORD_BITS 16
`define BYTE_BITS 8
`define TAG_STATUS 2'h3
`define TAG_HEADER 2'h2
`define HDR_CLR_BIT 5
`define STATUS_RSVD 1'h0

`endif

//--- hw/spi_chain_node.sv
`timescale 1ns/100ps
`include "spi_chain_defines.svh"
// Overview of operation
// - Sleep pin low: everything off, port disabled.
// - Sleep only after entry delay; wake delay.
// - Driver-off high: bridge Hi-Z, rest running.
// - Active when awake, driver on, supply good.
// - 5-20 us sleep pulse clears latched faults.
// - Longer low pulse clears faults, may sleep.
// - Clear pulse resets port faults only.
// - Command word: 0, rw, address, ignored, data.
// - Reply word: status byte then report byte.
// - Report shows register before write, or read.
// - Deselected: ignore SCLK/SDI, SDO Hi-Z.
// - Sample on fall, drive on rise, MSB first.
// - Wrong clock count: frame error, word dropped.
// - Chain output: statuses, headers, then reports.
// - Six-bit header count, up to 63 devices.
// - Header clear flag clears faults at deselect.
// - Header bytes start 1,0; second byte's low five bits ignored.
// - Own status byte starts 1,1 unasked.
// - Position from leading statuses; latch own bytes.
// - Protocol error flag, fault low until cleared.
module spi_chain_node
	import spi_chain_pkg::*;
#(
	parameter logic [10:0] SLEEP_CYC = 11'(`CLEAR_MAX_CYC),
	parameter logic [10:0] WAKE_CYC = 11'(`WAKE_CYC_DEF)
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Device pins
	input wire logic sleep_n_pin,
	input wire logic driver_off_pin,
	input wire logic motor_supply_ok,
	output logic fault_out_n,
	// Serial port pins
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	// Fault inputs from the protection logic
	input wire logic supply_undervoltage,
	input wire logic pump_undervoltage,
	input wire logic overcurrent,
	input wire logic thermal_flag,
	input wire logic open_load,
	input wire logic fault_active,
	input wire logic clear_fault_bit,
	// Register file access
	output logic [4:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	// Power control and status
	output logic bridge_enable,
	output logic regulator_enable,
	output logic pump_enable,
	output logic port_ready,
	output logic fault_clear,
	output logic frame_error,
	output logic protocol_error_flag
);
	import spi_chain_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rst_pipe;
	logic rst_n;
	logic [1:0] sleep_sy, cs_sy, sclk_sy, sdi_sy;
	logic sleep_s, cs_s, sclk_s, sdi_s, sclk_d;

	// Reset asserts at once, releases after two edges
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'h1};
		end
	end
	assign rst_n = rst_pipe[1];

	// Two flops on the sleep, select, clock and data pins; sclk gets a third for edge finding
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_sy <= 2'h0;
			cs_sy <= 2'h3;
			sclk_sy <= 2'h0;
			sdi_sy <= 2'h0;
			sclk_d <= 1'h0;
		end else if (clk_en) begin
			sleep_sy <= {sleep_sy[0], sleep_n_pin};
			cs_sy <= {cs_sy[0], chip_select_n};
			sclk_sy <= {sclk_sy[0], sclk};
			sdi_sy <= {sdi_sy[0], sdi};
			sclk_d <= sclk_sy[1];
		end
	end
	assign sleep_s = sleep_sy[1];
	assign cs_s = cs_sy[1];
	assign sclk_s = sclk_sy[1];
	assign sdi_s = sdi_sy[1];

	////////////////////////////////////////////////////////////////////////////
	// Power state and sleep pulse timing
	mode_t mode_reg, mode_next;
	logic [10:0] low_cnt_reg, low_cnt_next;
	logic [10:0] wake_cnt_reg, wake_cnt_next;
	logic pin_clr_reg, pin_clr_next;

	always_comb begin
		mode_next = mode_reg;
		low_cnt_next = low_cnt_reg;
		wake_cnt_next = wake_cnt_reg;
		pin_clr_next = 1'h0;
		if (!sleep_s) begin
			if (low_cnt_reg != `LOW_CNT_MAX)
				low_cnt_next = low_cnt_reg + 11'h1;
			// sleep only once the entry delay is over
			if (low_cnt_reg >= SLEEP_CYC)
				mode_next = MODE_SLEEP;
		end else begin
			// qualified pulse clears faults; longer ones too
			if (low_cnt_reg >= 11'(`DEGLITCH_CYC))
				pin_clr_next = 1'h1;
			low_cnt_next = 11'h0;
			case (mode_reg)
				MODE_SLEEP: begin
					mode_next = MODE_WAKE;
					wake_cnt_next = 11'h0;
				end
				MODE_WAKE: begin
					// inputs wait for the wake delay
					wake_cnt_next = wake_cnt_reg + 11'h1;
					if (wake_cnt_reg >= WAKE_CYC)
						mode_next = MODE_DISABLE;
				end
				MODE_DISABLE, MODE_ACTIVE: begin
					mode_next = (!driver_off_pin && motor_supply_ok) ? MODE_ACTIVE : MODE_DISABLE;
				end
				default: mode_next = MODE_SLEEP;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= MODE_SLEEP;
			low_cnt_reg <= 11'h0;
			wake_cnt_reg <= 11'h0;
			pin_clr_reg <= 1'h0;
		end else if (clk_en) begin
			mode_reg <= mode_next;
			low_cnt_reg <= low_cnt_next;
			wake_cnt_reg <= wake_cnt_next;
			pin_clr_reg <= pin_clr_next;
		end
	end

	// sleep turns all supplies and drivers off
	assign regulator_enable = (mode_reg != MODE_SLEEP);
	assign pump_enable = (mode_reg != MODE_SLEEP);
	assign bridge_enable = (mode_reg == MODE_ACTIVE);
	assign port_ready = (mode_reg == MODE_DISABLE) || (mode_reg == MODE_ACTIVE);

	////////////////////////////////////////////////////////////////////////////
	// Serial frame engine
	phase_t ph_reg, ph_next;
	logic cs_d_reg, cs_d_next;
	logic [10:0] bit_reg, bit_next, out_reg, out_next;
	logic [7:0] rx_reg, rx_next, stat_reg, stat_next, rep_reg, rep_next;
	logic [7:0] slot_reg, slot_next, base_reg, base_next;
	logic [5:0] pos_reg, pos_next, cnt_reg, cnt_next;
	logic [4:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic rw_reg, rw_next, gclr_reg, gclr_next, load_reg, load_next;
	logic sdo_reg, sdo_next, oe_reg, oe_next;
	logic we_reg, we_next, ferr_reg, ferr_next, hclr_reg, hclr_next;
	logic clr_reg, clr_next, perr_reg, perr_next, fout_reg, fout_next;
	logic cs_act, fall, rise;
	logic [7:0] b, ob;
	logic [10:0] exp_bits;

	// Single frames need one word; chain frames scale with count
	function automatic logic [10:0] frame_bits(input phase_t ph, input logic [7:0] base,
		input logic [5:0] n);
		if (ph == PH_SINGLE)
			frame_bits = 11'(`WORD_BITS);
		else if (ph == PH_BODY && n != 6'h0)
			frame_bits = 11'({base + {1'h0, n, 1'h0}, 3'h0});
		else
			frame_bits = 11'h0;
	endfunction

	// port only listens while selected and awake
	assign cs_act = !cs_s && port_ready;
	assign fall = cs_act && !cs_d_reg && sclk_d && !sclk_s;
	assign rise = cs_act && !cs_d_reg && !sclk_d && sclk_s;

	always_comb begin
		ph_next = ph_reg;
		cs_d_next = !cs_act;
		bit_next = bit_reg;
		out_next = out_reg;
		rx_next = rx_reg;
		stat_next = stat_reg;
		rep_next = load_reg ? reg_rdata : rep_reg;
		slot_next = slot_reg;
		base_next = base_reg;
		pos_next = pos_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		rw_next = rw_reg;
		gclr_next = gclr_reg;
		load_next = 1'h0;
		sdo_next = sdo_reg;
		oe_next = cs_act;
		we_next = 1'h0;
		ferr_next = 1'h0;
		hclr_next = 1'h0;
		b = bit_reg[10:3];
		ob = 8'(out_reg[10:3] - 8'h1);
		exp_bits = frame_bits(ph_reg, base_reg, cnt_reg);
		if (cs_act && cs_d_reg) begin
			// Frame start; status byte snapshot
			ph_next = PH_FIRST;
			bit_next = 11'h0;
			out_next = 11'h0;
			slot_next = 8'hFF;
			pos_next = 6'h0;
			gclr_next = 1'h0;
			stat_next = {`TAG_STATUS, supply_undervoltage, pump_undervoltage, overcurrent,
				`STATUS_RSVD, thermal_flag, open_load};
		end else if (!cs_act && !cs_d_reg) begin
			// check the clock count at deselect
			if (bit_reg == exp_bits && exp_bits != 11'h0) begin
				we_next = !rw_reg;
				hclr_next = gclr_reg;
			end else begin
				ferr_next = 1'h1;
			end
		end
		if (fall) begin
			// sample on falling edge, MSB first
			rx_next = {rx_reg[6:0], sdi_s};
			if (bit_reg != `LOW_CNT_MAX)
				bit_next = bit_reg + 11'h1;
			if (bit_reg[2:0] == 3'h7) begin
				case (ph_reg)
					PH_FIRST, PH_STATUS: begin
						if (rx_next[7:6] == `TAG_STATUS && pos_reg != 6'h3F) begin
							pos_next = pos_reg + 6'h1;
							ph_next = PH_STATUS;
						end else if (rx_next[7:6] == `TAG_HEADER) begin
							cnt_next = rx_next[5:0];
							ph_next = PH_HEADER_BYTE_SECOND;
						end else if (ph_reg == PH_FIRST && !rx_next[7]) begin
							// single word, address in bits 13..9
							rw_next = rx_next[6];
							addr_next = rx_next[5:1];
							slot_next = 8'h0;
							load_next = 1'h1;
							ph_next = PH_SINGLE;
						end else begin
							ph_next = PH_BAD;
						end
					end
					PH_HEADER_BYTE_SECOND: begin
						gclr_next = rx_next[`HDR_CLR_BIT];
						base_next = 8'(b + 8'h1);
						slot_next = 8'(b + 8'h1 + {2'h0, pos_reg});
						ph_next = (rx_next[7:6] == `TAG_HEADER && pos_reg < cnt_reg) ? PH_BODY
							: PH_BAD;
					end
					PH_BODY: begin
						// latch only own address and data
						if (b == slot_reg) begin
							rw_next = rx_next[6];
							addr_next = rx_next[5:1];
							load_next = 1'h1;
						end
						if (b == 8'(slot_reg + {2'h0, cnt_reg}))
							data_next = rx_next;
					end
					PH_SINGLE: begin
						if (b == 8'h1)
							data_next = rx_next;
					end
					default: ph_next = PH_BAD;
				endcase
			end
		end
		if (rise) begin
			if (out_reg < 11'(`BYTE_BITS))
				sdo_next = stat_reg[3'h7 - out_reg[2:0]];
			// own slot carries the report, read before any write
			else if (ob == slot_reg)
				sdo_next = rep_reg[3'h7 - out_reg[2:0]];
			// other bytes forwarded one byte late
			else
				sdo_next = rx_reg[7];
			if (out_reg != `LOW_CNT_MAX)
				out_next = out_reg + 11'h1;
		end
		// port faults clear by pin pulse, register bit or header
		clr_next = pin_clr_reg || clear_fault_bit || hclr_reg;
		// error stays until cleared; a new error wins
		perr_next = ferr_reg || (perr_reg && !clr_reg);
		fout_next = !(perr_next || fault_active);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_reg <= PH_FIRST;
			cs_d_reg <= 1'h1;
			bit_reg <= 11'h0;
			out_reg <= 11'h0;
			rx_reg <= 8'h0;
			stat_reg <= 8'h0;
			rep_reg <= 8'h0;
			slot_reg <= 8'hFF;
			base_reg <= 8'h0;
			pos_reg <= 6'h0;
			cnt_reg <= 6'h0;
			addr_reg <= 5'h0;
			data_reg <= 8'h0;
			rw_reg <= 1'h1;
			gclr_reg <= 1'h0;
			load_reg <= 1'h0;
			sdo_reg <= 1'h0;
			oe_reg <= 1'h0;
			we_reg <= 1'h0;
			ferr_reg <= 1'h0;
			hclr_reg <= 1'h0;
			clr_reg <= 1'h0;
			perr_reg <= 1'h0;
			fout_reg <= 1'h1;
		end else if (clk_en) begin
			ph_reg <= ph_next;
			cs_d_reg <= cs_d_next;
			bit_reg <= bit_next;
			out_reg <= out_next;
			rx_reg <= rx_next;
			stat_reg <= stat_next;
			rep_reg <= rep_next;
			slot_reg <= slot_next;
			base_reg <= base_next;
			pos_reg <= pos_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			rw_reg <= rw_next;
			gclr_reg <= gclr_next;
			load_reg <= load_next;
			sdo_reg <= sdo_next;
			oe_reg <= oe_next;
			we_reg <= we_next;
			ferr_reg <= ferr_next;
			hclr_reg <= hclr_next;
			clr_reg <= clr_next;
			perr_reg <= perr_next;
			fout_reg <= fout_next;
		end
	end

	// Outputs straight from flops
	assign reg_addr = addr_reg;
	assign reg_wdata = data_reg;
	assign reg_we = we_reg;
	assign sdo_o = sdo_reg;
	assign sdo_oe = oe_reg;
	assign frame_error = ferr_reg;
	assign fault_clear = clr_reg;
	assign protocol_error_flag = perr_reg;
	assign fault_out_n = fout_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sleep_all_off_a: assert property (clk_en && !sleep_s && low_cnt_reg >= SLEEP_CYC
		|=> !pump_enable && !regulator_enable && !port_ready && !bridge_enable)
		else $error("sleep left blocks on");
	sleep_entry_delay_a: assert property (clk_en && $rose(mode_reg == MODE_SLEEP)
		|-> $past(low_cnt_reg) >= SLEEP_CYC) else $error("sleep entered early");
	driver_off_hiz_a: assert property (clk_en && sleep_s && driver_off_pin && port_ready
		|=> !bridge_enable && pump_enable) else $error("bridge on while disabled");
	wake_before_active_a: assert property (clk_en && $rose(port_ready)
		|-> $past(wake_cnt_reg) >= WAKE_CYC) else $error("ready before wake delay");
	glitch_ignored_a: assert property (clk_en && sleep_s && low_cnt_reg != 11'h0
		&& low_cnt_reg < 11'(`DEGLITCH_CYC) |=> !pin_clr_reg) else $error("glitch cleared faults");
	pulse_clears_a: assert property (clk_en && sleep_s && low_cnt_reg >= 11'(`DEGLITCH_CYC)
		|=> pin_clr_reg) else $error("valid pulse ignored");
	deselect_hiz_a: assert property (clk_en && cs_s |=> !sdo_oe)
		else $error("sdo driven while deselected");
	bad_frame_no_write_a: assert property (frame_error |-> !reg_we)
		else $error("write despite frame error");
	error_pulls_fault_a: assert property (clk_en && frame_error
		|=> protocol_error_flag && !fault_out_n) else $error("error not flagged");
endmodule

//--- hw/spi_chain_pkg.sv
package spi_chain_pkg;
	// Device power states
	typedef enum logic [1:0] {MODE_SLEEP, MODE_WAKE, MODE_DISABLE, MODE_ACTIVE} mode_t;
	// Position of the frame parser in the byte stream
	typedef enum logic [2:0] {PH_FIRST, PH_STATUS, PH_HEADER_BYTE_SECOND, PH_BODY, PH_SINGLE, PH_BAD} phase_t;
endpackage

//--- sim/spi_chain_node_tb_top.sv
`timescale 1ns/100ps
// Bench for the serial port and power states
module spi_chain_node_tb_top;
	localparam int WAKE = 50;
	logic ref_clk = 1'h0;
	logic resetn = 1'h0;
	logic sleep_n_pin = 1'h0;
	logic driver_off_pin = 1'h1;
	logic clear_fault_bit = 1'h0;
	logic clk_en = 1'h1;
	logic motor_supply_ok = 1'h1;
	logic fault_active = 1'h0;
	logic [4:0] flt = 5'h00;
	logic chip_select_n, sclk, sdi, sdo_o, sdo_oe, sdo_line, fault_out_n, reg_we;
	logic bridge_enable, regulator_enable, pump_enable, port_ready;
	logic fault_clear, frame_error, protocol_error_flag;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [7:0] regs [32];
	logic [31:0] rx;
	int n_errors = 0;
	int checked = 0;
	int n_we = 0;
	int n_clr = 0;
	int n_ferr = 0;
	int n_oe = 0;
	////////////////////////////////////////
	// Clock, released data line, register file and pulse counters
	always #10 ref_clk = ~ref_clk;
	assign sdo_line = sdo_oe ? sdo_o : ~sdo_o;
	assign reg_rdata = regs[reg_addr];
	always @(posedge ref_clk) begin
		if (reg_we) begin
			regs[reg_addr] <= reg_wdata;
			n_we <= n_we + 1;
		end
		n_clr <= n_clr + int'(fault_clear);
		n_ferr <= n_ferr + int'(frame_error);
		n_oe <= n_oe + int'(sdo_oe);
	end
	spi_chain_node i_spi_chain_node (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
		.sleep_n_pin(sleep_n_pin), .driver_off_pin(driver_off_pin),
		.motor_supply_ok(motor_supply_ok), .fault_out_n(fault_out_n),
		.chip_select_n(chip_select_n),
		.sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.supply_undervoltage(flt[4]), .pump_undervoltage(flt[3]), .overcurrent(flt[2]),
		.thermal_flag(flt[1]), .open_load(flt[0]), .fault_active(fault_active),
		.clear_fault_bit(clear_fault_bit), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .bridge_enable(bridge_enable),
		.regulator_enable(regulator_enable), .pump_enable(pump_enable),
		.port_ready(port_ready), .fault_clear(fault_clear), .frame_error(frame_error),
		.protocol_error_flag(protocol_error_flag));
	spi_master_model i_spi_master_model (.chip_select_n(chip_select_n), .sclk(sclk),
		.sdi(sdi), .sdo_line(sdo_line));
	////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'h1) begin
			n_errors++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask
	function automatic logic [7:0] stat();
		return {2'h3, flt[4:2], 1'h0, flt[1:0]};
	endfunction
	task automatic wait_ready();
		int i;
		i = 0;
		while (port_ready !== 1'h1 && i < 400) begin
			@(posedge ref_clk);
			i++;
		end
		chk(i >= WAKE && i < 400, "wake delay");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	// Scenarios
	task automatic t_power();
		chk(regulator_enable === 1'h0 && pump_enable === 1'h0, "asleep");
		chk(bridge_enable === 1'h0 && port_ready === 1'h0, "port off");
		@(posedge ref_clk) sleep_n_pin <= 1'h1;
		wait_ready();
		chk(pump_enable === 1'h1 && bridge_enable === 1'h0, "driver parked");
		driver_off_pin <= 1'h0;
		motor_supply_ok <= 1'h0;
		repeat (3) @(posedge ref_clk);
		chk(bridge_enable === 1'h0, "supply low");
		motor_supply_ok <= 1'h1;
		repeat (3) @(posedge ref_clk);
		chk(bridge_enable === 1'h1 && regulator_enable === 1'h1, "operating");
		// Low enable must hold the mode; driver-off acts once released
		clk_en <= 1'h0;
		driver_off_pin <= 1'h1;
		repeat (4) @(posedge ref_clk);
		chk(bridge_enable === 1'h1, "enable freeze");
		clk_en <= 1'h1;
		repeat (3) @(posedge ref_clk);
		chk(bridge_enable === 1'h0 && pump_enable === 1'h1, "driver off");
		driver_off_pin <= 1'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic t_word(input logic rw, input logic [4:0] a, input logic [7:0] d);
		logic [7:0] old;
		int w0;
		old = regs[a];
		w0 = n_we;
		i_spi_master_model.frame({16'h0000, 1'h0, rw, a, 1'h0, d}, 16, 1'h1, rx);
		chk(rx[15:0] === {stat(), old}, "reply word");
		chk(n_we - w0 == (rw ? 0 : 1), "write strobe");
		chk(regs[a] === (rw ? old : d), "register contents");
	endtask
	task automatic t_desel();
		int s0;
		s0 = n_ferr + n_we + n_oe;
		i_spi_master_model.frame(32'h0000_0A55, 16, 1'h0, rx);
		chk(n_ferr + n_we + n_oe == s0 && sdo_oe === 1'h0, "deselected traffic");
	endtask
	task automatic t_bad(input logic [31:0] tx, input int nb);
		int f0;
		int w0;
		f0 = n_ferr;
		w0 = n_we;
		i_spi_master_model.frame(tx, nb, 1'h1, rx);
		chk(n_ferr - f0 == 1 && n_we == w0, "frame dropped");
		chk(protocol_error_flag === 1'h1 && fault_out_n === 1'h0, "error shown");
	endtask
	task automatic t_pulse(input int cyc, input logic clr, input logic on);
		int c0;
		c0 = n_clr;
		@(posedge ref_clk) sleep_n_pin <= 1'h0;
		repeat (cyc) @(posedge ref_clk);
		chk(regulator_enable === on && pump_enable === on, "sleep entry");
		sleep_n_pin <= 1'h1;
		if (on)
			repeat (8) @(posedge ref_clk);
		else
			wait_ready();
		chk(n_clr - c0 == (clr ? 1 : 0) && pump_enable === 1'h1, "pulse clear");
	endtask
	task automatic t_clrbit();
		int c0;
		c0 = n_clr;
		@(posedge ref_clk) clear_fault_bit <= 1'h1;
		@(posedge ref_clk) clear_fault_bit <= 1'h0;
		repeat (3) @(posedge ref_clk);
		chk(n_clr - c0 == 1 && fault_out_n === 1'h1, "clear bit");
		fault_active <= 1'h1;
		repeat (3) @(posedge ref_clk);
		chk(fault_out_n === 1'h0 && pump_enable === 1'h1, "fault pin");
		fault_active <= 1'h0;
	endtask
	task automatic t_chain();
		logic [7:0] old;
		int c0;
		old = regs[7];
		c0 = n_clr;
		// one device, clear flag set, spare header bits used
		i_spi_master_model.frame(32'h81A5_0E3C, 32, 1'h1, rx);
		chk(rx === {stat(), 8'h81, 8'hA5, old}, "chain order");
		chk(regs[7] === 8'h3C, "own bytes latched");
		chk(n_clr - c0 == 1 && protocol_error_flag === 1'h0, "header clear");
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		for (int i = 0; i < 32; i++)
			regs[i] = 8'(i * 7);
		repeat (8) @(posedge ref_clk);
		resetn <= 1'h1;
		t_power();
		flt <= 5'h19;
		t_word(1'h0, 5'h03, 8'hA5);
		flt <= 5'h06;
		t_word(1'h1, 5'h03, 8'h00);
		t_word(1'h0, 5'h1F, 8'h5A);
		t_desel();
		t_bad(32'h0000_06A5, 15);
		t_pulse(100, 1'h0, 1'h1);
		chk(protocol_error_flag === 1'h1, "glitch ignored");
		t_pulse(400, 1'h1, 1'h1);
		chk(protocol_error_flag === 1'h0 && fault_out_n === 1'h1, "flag cleared");
		t_bad(32'h0000_4C5A, 17);
		t_clrbit();
		t_bad(32'hC081_A00E, 32);
		t_bad(32'h80A0_0E3C, 32);
		t_chain();
		t_pulse(1300, 1'h1, 1'h0);
		t_word(1'h1, 5'h07, 8'h00);
		wrap_up();
	end
	// Whole run is near 80 us; a hang is cut well after that
	initial begin
		#400000;
		n_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule

//--- sim/spi_master_model.sv
`timescale 1ns/100ps
// Controller side of the serial link, clocking at 160 ns per bit
module spi_master_model (
	// Serial pins toward the device
	output logic chip_select_n,
	output logic sclk,
	output logic sdi,
	// Resolved data line from the device
	input wire logic sdo_line
);
	// Idle link: deselected, clock parked low
	initial begin
		chip_select_n = 1'h1;
		sclk = 1'h0;
		sdi = 1'h0;
	end
	////////////////////////////////////////
	// clock low at select edges, MSB first, long gap
	task automatic frame(input logic [31:0] tx, input int nb, input logic sel,
		output logic [31:0] rx);
		rx = '0;
		// Step off the system clock edge so pins never race the samplers
		#5;
		chip_select_n = ~sel;
		sdi = tx[nb - 1];
		#160;
		for (int i = nb - 1; i >= 0; i--) begin
			sclk = 1'h1;
			sdi = tx[i];
			#80 sclk = 1'h0;
			// Sample late in the low phase, the reply lags the rise
			#80 rx = {rx[30:0], sdo_line};
		end
		chip_select_n = 1'h1;
		// Released line flips so a stale value is never mistaken for data
		sdi = ~sdi;
		// Gap of 600 ns in all, back on the edge grid for the caller
		#595;
	endtask
endmodule
